// *** rtl/dsa_data_space.sv ***
// Data space access unit: decode, byte lanes, working registers and alignment trap
`timescale 1ns/1ps
// Contract
// RULE1 - Effective addresses are 16-bit byte addresses
// RULE2 - Bit 15 clear memory, set view window
// RULE3 - Reads beyond implemented area return zero
// RULE4 - Low byte even address, high odd
// RULE5 - Post-increment adds one byte, two word
// RULE6 - Byte read selects by bit zero, low
// RULE7 - Shared word decode, separate byte write strobes
// RULE8 - Odd-address word access raises address trap
// RULE9 - Misaligned read completes, misaligned write suppressed
// RULE10 - Byte load keeps working register high byte
// RULE11 - Separate read and write address paths
// RULE12 - Sign-extend and zero-extend working registers
// RULE13 - Mapped working registers follow active context
// RULE14 - Loop start registers read-only to writes
// RULE15 - Word writes both strobes, byte one
module dsa_data_space
   import dsa_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Read address path
   input wire logic rdReq,
   input wire logic [EA_W-1:0] rdAddr,
   input wire logic rdIsByte,
   // Write address path
   input wire logic wrReq,
   input wire logic [EA_W-1:0] wrAddr,
   input wire logic wrIsByte,
   input wire logic [DATA_W-1:0] wrData,
   // Program space view window data
   input wire logic [DATA_W-1:0] winRdData,
   // Core register side
   input wire logic [CTX_W-1:0] ctxSel,
   input wire logic regLoadEn,
   input wire logic [WREG_IDX_W-1:0] regLoadIdx,
   input wire logic regLoadByte,
   input wire logic [DATA_W-1:0] regLoadData,
   input wire dsa_ext_t extOp,
   input wire logic [WREG_IDX_W-1:0] extIdx,
   input wire logic [DATA_W-1:0] loopStartLow,
   input wire logic [DATA_W-1:0] loopStartHigh,
   // Results
   output logic [DATA_W-1:0] rdData_q,
   output logic rdValid_q,
   output logic winRead_q,
   output logic [EA_W-1:0] rdPtrNext_q,
   output logic [EA_W-1:0] wrPtrNext_q,
   output logic [1:0] wrStrobe_q,
   output logic addrErrTrap_q
);
   // Alignment checks: word access at an odd address
   wire logic rdMis = rdReq && !rdIsByte && rdAddr[EA_BYTE_BIT]; // RULE8
   wire logic wrMis = wrReq && !wrIsByte && wrAddr[EA_BYTE_BIT]; // RULE8
   // A misaligned write is dropped here; the read still runs
   wire logic wrGo = wrReq && !wrMis; // RULE9

   // Independent decode for each address path
   wire logic rdWindow = rdAddr[EA_WINDOW_BIT]; // RULE2
   wire logic wrWindow = wrAddr[EA_WINDOW_BIT]; // RULE2
   wire logic rdInRam = !rdWindow && rdAddr >= RAM_BASE && rdAddr < RAM_LIMIT; // RULE11
   wire logic wrInRam = !wrWindow && wrAddr >= RAM_BASE && wrAddr < RAM_LIMIT; // RULE11
   wire logic rdInWreg = rdAddr < WREG_LIMIT;
   wire logic wrInWreg = wrAddr < WREG_LIMIT;
   wire logic rdIsLoopLow = rdAddr[EA_W-1:1] == LOOP_START_LOW_ADDR[EA_W-1:1];
   wire logic rdIsLoopHigh = rdAddr[EA_W-1:1] == LOOP_START_HIGH_ADDR[EA_W-1:1];

   // Word index into memory; bit zero only picks the lane
   wire logic [EA_W-1:0] rdRamOff = rdAddr - RAM_BASE;
   wire logic [EA_W-1:0] wrRamOff = wrAddr - RAM_BASE;
   wire logic [RAM_AW-1:0] rdRamIdx = rdRamOff[RAM_AW:1]; // RULE7
   wire logic [RAM_AW-1:0] wrRamIdx = wrRamOff[RAM_AW:1]; // RULE7
   wire logic [WREG_IDX_W-1:0] rdWregIdx = rdAddr[WREG_IDX_LSB +: WREG_IDX_W];
   wire logic [WREG_IDX_W-1:0] wrWregIdx = wrAddr[WREG_IDX_LSB +: WREG_IDX_W];

   // Byte lane strobes: low lane is the even address
   wire logic [1:0] wrLane = !wrIsByte ? LANE_BOTH :
      (wrAddr[EA_BYTE_BIT] ? LANE_HIGH : LANE_LOW); // RULE15 RULE4
   wire logic [1:0] wrLaneGo = wrGo ? wrLane : LANE_NONE; // RULE9
   // A byte write arrives on the low byte; copy it to both lanes
   wire logic [DATA_W-1:0] wrLaneData = wrIsByte ? {wrData[BYTE_W-1:0], wrData[BYTE_W-1:0]} : wrData;

   // Implemented memory as two byte-wide halves
   logic [BYTE_W-1:0] ramRdLow;
   logic [BYTE_W-1:0] ramRdHigh;
   dsa_byte_lane u_lane_low
   (
      .clk(clk),
      .wrEn(wrLaneGo[0] && wrInRam), // RULE7
      .wrIdx(wrRamIdx),
      .wrByte(wrLaneData[BYTE_W-1:0]),
      .rdIdx(rdRamIdx),
      .rdByte(ramRdLow)
   );
   dsa_byte_lane u_lane_high
   (
      .clk(clk),
      .wrEn(wrLaneGo[1] && wrInRam), // RULE7
      .wrIdx(wrRamIdx),
      .wrByte(wrLaneData[DATA_W-1:BYTE_W]),
      .rdIdx(rdRamIdx),
      .rdByte(ramRdHigh)
   );

   // Next value of one working register; core load beats extend beats data space
   function automatic logic [DATA_W-1:0] wreg_next
   (
      input logic [DATA_W-1:0] cur,
      input logic loadHit,
      input logic extHit,
      input logic dsHit
   );
      logic [DATA_W-1:0] nxt;
      nxt = cur;
      if (loadHit)
      begin
         if (regLoadByte)
            nxt[BYTE_W-1:0] = regLoadData[BYTE_W-1:0]; // RULE10
         else
            nxt = regLoadData;
      end
      else if (extHit)
      begin
         if (extOp == EXT_SIGN)
            nxt[DATA_W-1:BYTE_W] = {BYTE_W{cur[BYTE_W-1]}}; // RULE12
         else if (extOp == EXT_ZERO)
            nxt[DATA_W-1:BYTE_W] = ZERO_BYTE; // RULE12
      end
      else if (dsHit)
      begin
         if (wrLaneGo[0])
            nxt[BYTE_W-1:0] = wrLaneData[BYTE_W-1:0]; // RULE7
         if (wrLaneGo[1])
            nxt[DATA_W-1:BYTE_W] = wrLaneData[DATA_W-1:BYTE_W]; // RULE7
      end
      return nxt;
   endfunction : wreg_next

   // Banked working registers, one set per context, plus the shared stack register
   logic [DATA_W-1:0] wBank_q [NUM_CTX][NUM_BANKED];
   logic [DATA_W-1:0] w15_q;
   wire logic extActive = extOp != EXT_NONE;
   wire logic dsWregWr = wrGo && wrInWreg;

   for (genvar c = 0; c < NUM_CTX; c++)
   begin : g_ctx
      for (genvar i = 0; i < NUM_BANKED; i++)
      begin : g_reg
         // Only the active context sees loads and mapped writes
         wire logic ctxHit = ctxSel == CTX_W'(c); // RULE13
         wire logic loadHit = ctxHit && regLoadEn && regLoadIdx == WREG_IDX_W'(i);
         wire logic extHit = ctxHit && extActive && extIdx == WREG_IDX_W'(i);
         wire logic dsHit = ctxHit && dsWregWr && wrWregIdx == WREG_IDX_W'(i); // RULE13
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               wBank_q[c][i] <= ZERO_WORD;
            else
               wBank_q[c][i] <= wreg_next(wBank_q[c][i], loadHit, extHit, dsHit);
         end
      end
   end

   // The stack register is not banked
   wire logic w15Load = regLoadEn && regLoadIdx == WREG_SHARED_IDX;
   wire logic w15Ext = extActive && extIdx == WREG_SHARED_IDX;
   wire logic w15Ds = dsWregWr && wrWregIdx == WREG_SHARED_IDX;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         w15_q <= ZERO_WORD;
      else
         w15_q <= wreg_next(w15_q, w15Load, w15Ext, w15Ds);
   end

   // Read selection; contexts beyond the implemented ones read the shared set
   wire logic [CTX_W-1:0] rdCtx = ctxSel < CTX_W'(NUM_CTX) ? ctxSel : SHARED_CTX;
   wire logic [DATA_W-1:0] wregRdWord = rdWregIdx == WREG_SHARED_IDX ? w15_q :
      wBank_q[rdCtx][rdWregIdx]; // RULE13
   // Loop start registers are visible to reads; no write path reaches them
   wire logic [DATA_W-1:0] rdWord = rdWindow ? winRdData :
      rdInRam ? {ramRdHigh, ramRdLow} :
      rdInWreg ? wregRdWord :
      rdIsLoopLow ? loopStartLow : // RULE14
      rdIsLoopHigh ? loopStartHigh : // RULE14
      ZERO_WORD; // RULE3
   // Byte reads use the whole word and place the chosen byte low
   wire logic [BYTE_W-1:0] rdSelByte = rdAddr[EA_BYTE_BIT] ? rdWord[DATA_W-1:BYTE_W] :
      rdWord[BYTE_W-1:0]; // RULE6 RULE4
   wire logic [DATA_W-1:0] rdResult = rdIsByte ? {ZERO_BYTE, rdSelByte} : rdWord; // RULE6

   // Post-increment steps per path
   wire logic [EA_W-1:0] rdStep = rdIsByte ? STEP_BYTE : STEP_WORD; // RULE5
   wire logic [EA_W-1:0] wrStep = wrIsByte ? STEP_BYTE : STEP_WORD; // RULE5

   // Read results; a misaligned word read still returns its data
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdData_q <= ZERO_WORD;
         rdValid_q <= 1'b0;
         winRead_q <= 1'b0;
      end
      else
      begin
         rdData_q <= rdReq ? rdResult : rdData_q; // RULE9
         rdValid_q <= rdReq;
         winRead_q <= rdReq && rdWindow; // RULE2
      end
   end

   // Pointer updates, lane strobes of each aligned write to any address, and the trap one cycle later
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdPtrNext_q <= WREG_BASE;
         wrPtrNext_q <= WREG_BASE;
         wrStrobe_q <= LANE_NONE;
         addrErrTrap_q <= 1'b0;
      end
      else
      begin
         rdPtrNext_q <= rdReq ? rdAddr + rdStep : rdPtrNext_q; // RULE5 RULE1
         wrPtrNext_q <= wrReq ? wrAddr + wrStep : wrPtrNext_q; // RULE5 RULE1
         wrStrobe_q <= wrLaneGo; // RULE15
         addrErrTrap_q <= rdMis || wrMis; // RULE8
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence misWrite_s;
      wrReq && !wrIsByte && wrAddr[EA_BYTE_BIT];
   endsequence
   sequence trapNoStrobe_s;
      addrErrTrap_q && wrStrobe_q == LANE_NONE ##1 !addrErrTrap_q || $past(rdMis || wrMis);
   endsequence

   byte_strobe_a: assert property (wrReq && wrIsByte |=> // RULE15
      wrStrobe_q == ($past(wrAddr[EA_BYTE_BIT]) ? LANE_HIGH : LANE_LOW))
      else $error("byte write strobe lane wrong");
   mis_write_a: assert property (misWrite_s |=> trapNoStrobe_s) // RULE9
      else $error("misaligned write not trapped or not suppressed");
   mis_read_a: assert property (rdReq && !rdIsByte && rdAddr[EA_BYTE_BIT] |=> // RULE8
      addrErrTrap_q && rdValid_q)
      else $error("misaligned read not trapped or not completed");
   post_inc_a: assert property (rdReq |=> // RULE5
      rdPtrNext_q == $past(rdAddr) + ($past(rdIsByte) ? STEP_BYTE : STEP_WORD))
      else $error("read pointer step wrong");
   unimpl_zero_a: assert property (rdReq && !rdAddr[EA_WINDOW_BIT] && rdAddr >= RAM_LIMIT |=> // RULE3
      rdData_q == ZERO_WORD)
      else $error("unimplemented read not zero");
   byte_read_a: assert property (rdReq && rdIsByte |=> // RULE6
      rdData_q[DATA_W-1:BYTE_W] == ZERO_BYTE)
      else $error("byte read not on low byte");
   loop_start_a: assert property (rdReq && rdIsLoopLow && !rdIsByte |=> // RULE14
      rdData_q == $past(loopStartLow))
      else $error("loop start low read wrong");
   byte_load_a: assert property (w15Load && regLoadByte |=> // RULE10
      w15_q == {$past(w15_q[DATA_W-1:BYTE_W]), $past(regLoadData[BYTE_W-1:0])})
      else $error("byte load changed high byte");
   sign_ext_a: assert property (w15Ext && !w15Load && extOp == EXT_SIGN |=> // RULE12
      w15_q[DATA_W-1:BYTE_W] == {BYTE_W{$past(w15_q[BYTE_W-1])}})
      else $error("sign extend wrong");
   window_read_a: assert property (rdReq && rdWindow && !rdIsByte |=> // RULE2
      winRead_q && rdData_q == $past(winRdData))
      else $error("window read not routed");
endmodule : dsa_data_space

// *** rtl/dsa_pkg.sv ***
// Shared constants and types for the data space access unit
package dsa_pkg;
   // Address and data widths
   localparam int EA_W = 16;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int EA_WINDOW_BIT = 15;
   localparam int EA_BYTE_BIT = 0;
   // Memory-mapped working registers occupy one word each from the base
   localparam int WREG_IDX_W = 4;
   localparam int WREG_IDX_LSB = 1;
   localparam int NUM_CTX = 5;
   localparam int NUM_BANKED = 15;
   localparam int CTX_W = 3;
   localparam logic [EA_W-1:0] WREG_BASE = 16'h0000;
   localparam logic [EA_W-1:0] WREG_LIMIT = 16'h0020;
   localparam logic [WREG_IDX_W-1:0] WREG_SHARED_IDX = 4'hF;
   localparam logic [CTX_W-1:0] SHARED_CTX = 3'h0;
   // Read-only loop start address registers
   localparam logic [EA_W-1:0] LOOP_START_LOW_ADDR = 16'h0036;
   localparam logic [EA_W-1:0] LOOP_START_HIGH_ADDR = 16'h0038;
   // Implemented data memory: 16 Kbytes as 8K words
   localparam logic [EA_W-1:0] RAM_BASE = 16'h1000;
   localparam logic [EA_W-1:0] RAM_LIMIT = 16'h5000;
   localparam int RAM_WORDS = 8192;
   localparam int RAM_AW = 13;
   // Pointer steps and fixed values
   localparam logic [EA_W-1:0] STEP_BYTE = 16'h0001;
   localparam logic [EA_W-1:0] STEP_WORD = 16'h0002;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [1:0] LANE_NONE = 2'h0;
   localparam logic [1:0] LANE_LOW = 2'h1;
   localparam logic [1:0] LANE_HIGH = 2'h2;
   localparam logic [1:0] LANE_BOTH = 2'h3;
   // Register extend operations
   typedef enum logic [1:0]
   {
      EXT_NONE = 2'b00,
      EXT_SIGN = 2'b01,
      EXT_ZERO = 2'b10
   } dsa_ext_t;
endpackage : dsa_pkg

// *** rtl/dsa_byte_lane.sv ***
// One byte-wide half of the data memory with its own write strobe
`timescale 1ns/1ps
module dsa_byte_lane
   import dsa_pkg::*;
#(
   parameter int DEPTH = RAM_WORDS,
   parameter int AW = RAM_AW
)
(
   // Clock
   input wire logic clk,
   // Write side
   input wire logic wrEn,
   input wire logic [AW-1:0] wrIdx,
   input wire logic [BYTE_W-1:0] wrByte,
   // Read side, shared word decode
   input wire logic [AW-1:0] rdIdx,
   output logic [BYTE_W-1:0] rdByte
);
   logic [BYTE_W-1:0] mem [DEPTH];

   // Storage has no reset; contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrIdx] <= wrByte;
      end
   end

   assign rdByte = mem[rdIdx];
endmodule : dsa_byte_lane

// *** tb/dsa_psv_model.sv ***
// Program space view window model seen by the data space block
`timescale 1ns/1ps
module dsa_window_model
   import dsa_pkg::*;
(
   // Read address from the core
   input wire logic [EA_W-1:0] rdAddr,
   // Window word returned in the same cycle
   output logic [DATA_W-1:0] winRdData
);
   // Inverted address so every window word differs and a stale value cannot pass
   assign winRdData = ~rdAddr;
endmodule : dsa_window_model

// *** tb/testbench.sv ***
// Self-checking bench for the data space access unit
`timescale 1ns/1ps
module testbench
   import dsa_pkg::*;
;
   typedef struct packed {logic w; logic [15:0] a; logic b; logic [15:0] d; logic [15:0] e; logic t;} dsa_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rdReq = 1'b0;
   logic [EA_W-1:0] rdAddr = 16'h0000;
   logic rdIsByte = 1'b0;
   logic wrReq = 1'b0;
   logic [EA_W-1:0] wrAddr = 16'h0000;
   logic wrIsByte = 1'b0;
   logic [DATA_W-1:0] wrData = 16'h0000;
   logic [DATA_W-1:0] winRdData;
   logic [CTX_W-1:0] ctxSel = 3'h0;
   logic regLoadEn = 1'b0;
   logic [WREG_IDX_W-1:0] regLoadIdx = 4'h2;
   logic regLoadByte = 1'b0;
   logic [DATA_W-1:0] regLoadData = 16'h0000;
   dsa_ext_t extOp = EXT_NONE;
   logic [WREG_IDX_W-1:0] extIdx = 4'h2;
   logic [DATA_W-1:0] loopStartLow = 16'hA5C3;
   logic [DATA_W-1:0] loopStartHigh = 16'h005A;
   logic [DATA_W-1:0] rdData_q;
   logic rdValid_q;
   logic winRead_q;
   logic [EA_W-1:0] rdPtrNext_q;
   logic [EA_W-1:0] wrPtrNext_q;
   logic [1:0] wrStrobe_q;
   logic addrErrTrap_q;
   int failures = 0;
   int checked = 0;
   // Ordinary accesses: write rows expect lane strobes, read rows expect data
   dsa_row_t rows [$] = '{
      '{1'b1, 16'h1002, 1'b0, 16'hBEEF, 16'h0003, 1'b0},
      '{1'b0, 16'h1002, 1'b0, 16'h0000, 16'hBEEF, 1'b0},
      '{1'b1, 16'h1003, 1'b1, 16'h00AB, 16'h0002, 1'b0},
      '{1'b0, 16'h1002, 1'b0, 16'h0000, 16'hABEF, 1'b0},
      '{1'b0, 16'h1003, 1'b1, 16'h0000, 16'h00AB, 1'b0},
      '{1'b0, 16'h1002, 1'b1, 16'h0000, 16'h00EF, 1'b0},
      '{1'b1, 16'h1004, 1'b0, 16'h0000, 16'h0003, 1'b0},
      '{1'b1, 16'h1004, 1'b1, 16'h0011, 16'h0001, 1'b0},
      '{1'b1, 16'h1005, 1'b1, 16'h0022, 16'h0002, 1'b0},
      '{1'b0, 16'h1004, 1'b0, 16'h0000, 16'h2211, 1'b0},
      '{1'b1, 16'h1003, 1'b0, 16'h5555, 16'h0000, 1'b1},
      '{1'b0, 16'h1002, 1'b0, 16'h0000, 16'hABEF, 1'b0},
      '{1'b0, 16'h1003, 1'b0, 16'h0000, 16'hABEF, 1'b1},
      '{1'b1, 16'h4FFE, 1'b0, 16'h1234, 16'h0003, 1'b0},
      '{1'b0, 16'h4FFE, 1'b0, 16'h0000, 16'h1234, 1'b0},
      '{1'b0, 16'h5000, 1'b0, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 16'h7FFF, 1'b1, 16'h0000, 16'h0000, 1'b0},
      '{1'b0, 16'h8004, 1'b0, 16'h0000, 16'h7FFB, 1'b0},
      '{1'b0, 16'h8001, 1'b1, 16'h0000, 16'h007F, 1'b0},
      '{1'b1, 16'h0036, 1'b0, 16'hFFFF, 16'h0003, 1'b0},
      '{1'b0, 16'h0036, 1'b0, 16'h0000, 16'hA5C3, 1'b0},
      '{1'b1, 16'h0039, 1'b1, 16'h00FF, 16'h0002, 1'b0},
      '{1'b0, 16'h0038, 1'b0, 16'h0000, 16'h005A, 1'b0}
   };

   dsa_data_space i_dut (.clk(clk), .rst_n(rst_n), .rdReq(rdReq), .rdAddr(rdAddr), .rdIsByte(rdIsByte),
      .wrReq(wrReq), .wrAddr(wrAddr), .wrIsByte(wrIsByte), .wrData(wrData), .winRdData(winRdData),
      .ctxSel(ctxSel), .regLoadEn(regLoadEn), .regLoadIdx(regLoadIdx), .regLoadByte(regLoadByte),
      .regLoadData(regLoadData), .extOp(extOp), .extIdx(extIdx), .loopStartLow(loopStartLow),
      .loopStartHigh(loopStartHigh), .rdData_q(rdData_q), .rdValid_q(rdValid_q), .winRead_q(winRead_q),
      .rdPtrNext_q(rdPtrNext_q), .wrPtrNext_q(wrPtrNext_q), .wrStrobe_q(wrStrobe_q),
      .addrErrTrap_q(addrErrTrap_q));

   dsa_window_model i_window (.rdAddr(rdAddr), .winRdData(winRdData));

   // Free-running core clock
   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One access taken at the next rising edge, results checked at the falling edge after it
   task automatic op(input dsa_row_t r);
      @(negedge clk);
      rdReq = !r.w;
      rdAddr = r.a;
      rdIsByte = r.b;
      wrReq = r.w;
      wrAddr = r.a;
      wrIsByte = r.b;
      wrData = r.d;
      @(negedge clk);
      rdReq = 1'b0;
      wrReq = 1'b0;
      chk("trap", {15'h0000, addrErrTrap_q}, {15'h0000, r.t});
      if (r.w)
      begin
         chk("strobe", {14'h0000, wrStrobe_q}, r.e);
         chk("wrPtr", wrPtrNext_q, r.a + (r.b ? STEP_BYTE : STEP_WORD));
      end
      else
      begin
         chk("rdValid", {15'h0000, rdValid_q}, 16'h0001);
         chk("rdData", rdData_q, r.e);
         chk("winRead", {15'h0000, winRead_q}, {15'h0000, r.a[15]});
         chk("rdPtr", rdPtrNext_q, r.a + (r.b ? STEP_BYTE : STEP_WORD));
      end
   endtask : op

   // Register load or extend on the register set by regLoadIdx and extIdx; two, mapped at 0x0004, by default
   task automatic reg_op(input logic en, input logic byt, input logic [15:0] d, input dsa_ext_t x);
      @(negedge clk);
      regLoadEn = en;
      regLoadByte = byt;
      regLoadData = d;
      extOp = x;
      @(negedge clk);
      regLoadEn = 1'b0;
      extOp = EXT_NONE;
   endtask : reg_op

   task automatic end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // Watchdog well beyond the hundred or so cycles the sequence needs
   initial
   begin
      #50000;
      failures++;
      end_sim();
   end

   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[k]) op(rows[k]);
      // Read and write address paths used in the same cycle
      @(negedge clk);
      rdReq = 1'b1;
      rdAddr = 16'h1002;
      rdIsByte = 1'b0;
      wrReq = 1'b1;
      wrAddr = 16'h1007;
      wrIsByte = 1'b1;
      @(negedge clk);
      rdReq = 1'b0;
      wrReq = 1'b0;
      chk("parRd", rdData_q, 16'hABEF);
      chk("parStb", {14'h0000, wrStrobe_q}, 16'h0002);
      chk("parPtr", wrPtrNext_q, 16'h1008);
      // Byte load keeps the high byte, then both extend kinds
      reg_op(1'b1, 1'b0, 16'h1234, EXT_NONE);
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h1234, 1'b0});
      reg_op(1'b1, 1'b1, 16'h00CD, EXT_NONE);
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h12CD, 1'b0});
      reg_op(1'b0, 1'b0, 16'h0000, EXT_SIGN);
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'hFFCD, 1'b0});
      reg_op(1'b0, 1'b0, 16'h0000, EXT_ZERO);
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h00CD, 1'b0});
      // Second context has its own copy of the banked register
      ctxSel = 3'h1;
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h0000, 1'b0});
      op('{1'b1, 16'h0004, 1'b0, 16'h7777, 16'h0003, 1'b0});
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h7777, 1'b0});
      ctxSel = 3'h0;
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h00CD, 1'b0});
      // Shared stack register: byte load then sign extend, same in the second context
      regLoadIdx = 4'hF;
      extIdx = 4'hF;
      reg_op(1'b1, 1'b1, 16'h0080, EXT_NONE);
      op('{1'b0, 16'h001E, 1'b0, 16'h0000, 16'h0080, 1'b0});
      reg_op(1'b0, 1'b0, 16'h0000, EXT_SIGN);
      op('{1'b0, 16'h001E, 1'b0, 16'h0000, 16'hFF80, 1'b0});
      ctxSel = 3'h1;
      op('{1'b0, 16'h001E, 1'b0, 16'h0000, 16'hFF80, 1'b0});
      ctxSel = 3'h0;
      // Reset in mid-run clears outputs and working registers
      @(negedge clk);
      rst_n = 1'b0;
      #1;
      chk("rstData", rdData_q, 16'h0000);
      chk("rstPtr", rdPtrNext_q, 16'h0000);
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      op('{1'b0, 16'h0004, 1'b0, 16'h0000, 16'h0000, 1'b0});
      end_sim();
   end
endmodule : testbench
